// ---- rtl/gpp_pkg.sv ----
// package: register map, field positions and reset values of the port block
package gpp_pkg;
  // byte offsets as printed (not multiples of four: kept as indices)
  localparam logic [9:0] IDX_M_WOM = 10'h256;
  localparam logic [9:0] IDX_ROUTE = 10'h257;
  localparam logic [9:0] IDX_P_DATA = 10'h258;
  localparam logic [9:0] IDX_P_PIN = 10'h259;
  localparam logic [9:0] IDX_P_DIR = 10'h25A;
  localparam logic [9:0] IDX_P_RDR = 10'h25B;
  localparam logic [9:0] IDX_P_PULL = 10'h25C;
  localparam logic [9:0] IDX_P_POL = 10'h25D;
  localparam logic [9:0] IDX_P_IEN = 10'h25E;
  localparam logic [9:0] IDX_P_IFL = 10'h25F;
  localparam logic [9:0] IDX_H_DATA = 10'h260;
  localparam logic [9:0] IDX_H_PIN = 10'h261;
  localparam logic [9:0] IDX_H_DIR = 10'h262;
  localparam logic [9:0] IDX_H_RDR = 10'h263;
  localparam logic [9:0] IDX_H_PULL = 10'h264;
  // indices of our own for registers with no printed offset
  localparam logic [9:0] IDX_H_POL = 10'h265;
  localparam logic [9:0] IDX_H_IEN = 10'h266;
  localparam logic [9:0] IDX_H_IFL = 10'h267;
  localparam logic [9:0] IDX_K_DATA = 10'h268;
  localparam logic [9:0] IDX_K_DIR = 10'h269;
  // implemented-bit masks and reset values
  localparam logic [7:0] ROUTE_MASK = 8'hD0;
  localparam logic [7:0] K_MASK = 8'hBF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : gpp_pkg

// ---- rtl/gpp_port.sv ----
// gpio ports p, h, k and port m wired-or/routing control behind apb
//
// Behaviour
// - data read: register if output, else pin
// - read source follows direction bit only
// - general output drives data bit to pin
// - data writes affect pin only as output
// - pin input register read-only, returns pin
// - direction bit: 0 input, 1 output
// - peripheral ownership ignores direction for drive
// - configuration registers writable at any time
// - pull off while pin is driven push-pull
// - one bit per pin in each register
// - port k bit 6 absent
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port p pads
  input wire logic [7:0] p_pin_in,
  output logic [7:0] p_pin_out,
  output logic [7:0] p_pin_oe_n,
  output logic [7:0] p_pull_up,
  output logic [7:0] p_pull_down,
  output logic [7:0] p_drive_reduce,
  // port h pads
  input wire logic [7:0] h_pin_in,
  output logic [7:0] h_pin_out,
  output logic [7:0] h_pin_oe_n,
  output logic [7:0] h_pull_up,
  output logic [7:0] h_pull_down,
  output logic [7:0] h_drive_reduce,
  // port k pads
  input wire logic [7:0] k_pin_in,
  output logic [7:0] k_pin_out,
  output logic [7:0] k_pin_oe_n,
  // peripheral takeover of p and h pins
  input wire logic [7:0] p_periph_own,
  input wire logic [7:0] p_periph_out,
  input wire logic [7:0] p_periph_oe,
  input wire logic [7:0] h_periph_own,
  input wire logic [7:0] h_periph_out,
  input wire logic [7:0] h_periph_oe,
  // port m settings toward its pad logic
  output logic [7:0] open_drain_select,
  output logic [7:0] peripheral_routing_bits,
  // interrupt requests toward the interrupt controller
  output logic p_irq_req,
  output logic h_irq_req
);

  // one port's pin drive: peripheral first, direction ignored then
  function automatic logic [7:0] pad_oe(input logic [7:0] own, input logic [7:0] poe,
                                        input logic [7:0] dir);
    pad_oe = (own & poe) | (~own & dir);
  endfunction : pad_oe

  function automatic logic [7:0] pad_out(input logic [7:0] own, input logic [7:0] pout,
                                         input logic [7:0] dat);
    pad_out = (own & pout) | (~own & dat);
  endfunction : pad_out

  // data read: direction alone picks the source
  function automatic logic [7:0] data_rd(input logic [7:0] dir, input logic [7:0] dat,
                                         input logic [7:0] lvl);
    data_rd = (dir & dat) | (~dir & lvl);
  endfunction : data_rd

  // level filter: a bit moves only when stages 2 and 3 agree,
  // so a pad caught mid-transition cannot bounce the read value
  function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3,
                                        input logic [7:0] old);
    settle = (s2 & s3) | (old & (s2 ^ s3));
  endfunction : settle

  // edge pick: polarity 1 takes rising edges, 0 falling ones
  function automatic logic [7:0] pol_edge(input logic [7:0] pol, input logic [7:0] now,
                                          input logic [7:0] prev);
    pol_edge = (pol & now & ~prev) | (~pol & ~now & prev);
  endfunction : pol_edge

  // pin synchronisers, three stages, change counts when stages 2 and 3 agree
  logic [7:0] p_s1_ff, p_s2_ff, p_s3_ff, p_lvl_ff;
  logic [7:0] h_s1_ff, h_s2_ff, h_s3_ff, h_lvl_ff;
  logic [7:0] k_s1_ff, k_s2_ff, k_s3_ff, k_lvl_ff;
  logic [7:0] p_lvl_prev_ff, h_lvl_prev_ff;

  // configuration registers
  logic [7:0] m_wom_ff, route_ff;
  logic [7:0] p_dat_ff, p_dir_ff, p_rdr_ff, p_pull_ff, p_pol_ff, p_ien_ff, p_ifl_ff;
  logic [7:0] h_dat_ff, h_dir_ff, h_rdr_ff, h_pull_ff, h_pol_ff, h_ien_ff, h_ifl_ff;
  logic [7:0] k_dat_ff, k_dir_ff;

  // apb decode
  wire [9:0] idx = paddr[11:2];
  wire word_ok = paddr[1:0] == 2'b00;
  wire acc = psel && penable;
  wire wr = acc && pwrite && pstrb[0];
  wire hit_m_wom = word_ok && idx == IDX_M_WOM;
  wire hit_route = word_ok && idx == IDX_ROUTE;
  wire hit_p_dat = word_ok && idx == IDX_P_DATA;
  wire hit_p_pin = word_ok && idx == IDX_P_PIN;
  wire hit_p_dir = word_ok && idx == IDX_P_DIR;
  wire hit_p_rdr = word_ok && idx == IDX_P_RDR;
  wire hit_p_pull = word_ok && idx == IDX_P_PULL;
  wire hit_p_pol = word_ok && idx == IDX_P_POL;
  wire hit_p_ien = word_ok && idx == IDX_P_IEN;
  wire hit_p_ifl = word_ok && idx == IDX_P_IFL;
  wire hit_h_dat = word_ok && idx == IDX_H_DATA;
  wire hit_h_pin = word_ok && idx == IDX_H_PIN;
  wire hit_h_dir = word_ok && idx == IDX_H_DIR;
  wire hit_h_rdr = word_ok && idx == IDX_H_RDR;
  wire hit_h_pull = word_ok && idx == IDX_H_PULL;
  wire hit_h_pol = word_ok && idx == IDX_H_POL;
  wire hit_h_ien = word_ok && idx == IDX_H_IEN;
  wire hit_h_ifl = word_ok && idx == IDX_H_IFL;
  wire hit_k_dat = word_ok && idx == IDX_K_DATA;
  wire hit_k_dir = word_ok && idx == IDX_K_DIR;
  wire [7:0] wd = pwdata[7:0];

  // read mux; pin input registers accept no write
  wire [7:0] rd_byte;
  wire rd_hit;
  assign rd_hit = hit_m_wom | hit_route | hit_p_dat | hit_p_pin | hit_p_dir | hit_p_rdr |
                  hit_p_pull | hit_p_pol | hit_p_ien | hit_p_ifl | hit_h_dat | hit_h_pin |
                  hit_h_dir | hit_h_rdr | hit_h_pull | hit_h_pol | hit_h_ien | hit_h_ifl |
                  hit_k_dat | hit_k_dir;
  assign rd_byte =
    hit_m_wom ? m_wom_ff :
    hit_route ? route_ff :
    hit_p_dat ? data_rd(p_dir_ff, p_dat_ff, p_lvl_ff) :
    hit_p_pin ? p_lvl_ff :
    hit_p_dir ? p_dir_ff :
    hit_p_rdr ? p_rdr_ff :
    hit_p_pull ? p_pull_ff :
    hit_p_pol ? p_pol_ff :
    hit_p_ien ? p_ien_ff :
    hit_p_ifl ? p_ifl_ff :
    hit_h_dat ? data_rd(h_dir_ff, h_dat_ff, h_lvl_ff) :
    hit_h_pin ? h_lvl_ff :
    hit_h_dir ? h_dir_ff :
    hit_h_rdr ? h_rdr_ff :
    hit_h_pull ? h_pull_ff :
    hit_h_pol ? h_pol_ff :
    hit_h_ien ? h_ien_ff :
    hit_h_ifl ? h_ifl_ff :
    hit_k_dat ? (data_rd(k_dir_ff, k_dat_ff, k_lvl_ff) & K_MASK) :
    hit_k_dir ? (k_dir_ff & K_MASK) :
    8'h00;

  // interrupt edges: rising when polarity 1, falling when 0
  wire [7:0] p_edge = pol_edge(p_pol_ff, p_lvl_ff, p_lvl_prev_ff);
  wire [7:0] h_edge = pol_edge(h_pol_ff, h_lvl_ff, h_lvl_prev_ff);
  // flags clear by writing one; a new edge wins over the clear
  wire [7:0] nxt_p_ifl = (p_ifl_ff & ~((wr && hit_p_ifl) ? wd : 8'h00)) | p_edge;
  wire [7:0] nxt_h_ifl = (h_ifl_ff & ~((wr && hit_h_ifl) ? wd : 8'h00)) | h_edge;

  // pad drive and pulls
  wire [7:0] p_oe = pad_oe(p_periph_own, p_periph_oe, p_dir_ff);
  wire [7:0] h_oe = pad_oe(h_periph_own, h_periph_oe, h_dir_ff);
  wire [7:0] p_pull_on = p_pull_ff & ~p_oe;
  wire [7:0] h_pull_on = h_pull_ff & ~h_oe;

  // port p pin: three stages, filtered level and its previous value;
  // stage 1 feeds stage 2 only, nothing else reads a metastable bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      p_s1_ff <= REG_RESET;
      p_s2_ff <= REG_RESET;
      p_s3_ff <= REG_RESET;
      p_lvl_ff <= REG_RESET;
      p_lvl_prev_ff <= REG_RESET;
    end else begin
      p_s1_ff <= p_pin_in;
      p_s2_ff <= p_s1_ff;
      p_s3_ff <= p_s2_ff;
      p_lvl_ff <= settle(p_s2_ff, p_s3_ff, p_lvl_ff);
      p_lvl_prev_ff <= p_lvl_ff;
    end
  end

  // port h pin: same chain as port p
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      h_s1_ff <= REG_RESET;
      h_s2_ff <= REG_RESET;
      h_s3_ff <= REG_RESET;
      h_lvl_ff <= REG_RESET;
      h_lvl_prev_ff <= REG_RESET;
    end else begin
      h_s1_ff <= h_pin_in;
      h_s2_ff <= h_s1_ff;
      h_s3_ff <= h_s2_ff;
      h_lvl_ff <= settle(h_s2_ff, h_s3_ff, h_lvl_ff);
      h_lvl_prev_ff <= h_lvl_ff;
    end
  end

  // port k pin: no edge history, k has no interrupt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      k_s1_ff <= REG_RESET;
      k_s2_ff <= REG_RESET;
      k_s3_ff <= REG_RESET;
      k_lvl_ff <= REG_RESET;
    end else begin
      k_s1_ff <= k_pin_in;
      k_s2_ff <= k_s1_ff;
      k_s3_ff <= k_s2_ff;
      k_lvl_ff <= settle(k_s2_ff, k_s3_ff, k_lvl_ff);
    end
  end

  // port p configuration, accepted regardless of pin usage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      p_dat_ff <= REG_RESET;
      p_dir_ff <= REG_RESET;
      p_rdr_ff <= REG_RESET;
      p_pull_ff <= REG_RESET;
      p_pol_ff <= REG_RESET;
      p_ien_ff <= REG_RESET;
    end else if (wr) begin
      if (hit_p_dat) p_dat_ff <= wd;
      if (hit_p_dir) p_dir_ff <= wd;
      if (hit_p_rdr) p_rdr_ff <= wd;
      if (hit_p_pull) p_pull_ff <= wd;
      if (hit_p_pol) p_pol_ff <= wd;
      if (hit_p_ien) p_ien_ff <= wd;
    end
  end

  // port h configuration, same layout as port p
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      h_dat_ff <= REG_RESET;
      h_dir_ff <= REG_RESET;
      h_rdr_ff <= REG_RESET;
      h_pull_ff <= REG_RESET;
      h_pol_ff <= REG_RESET;
      h_ien_ff <= REG_RESET;
    end else if (wr) begin
      if (hit_h_dat) h_dat_ff <= wd;
      if (hit_h_dir) h_dir_ff <= wd;
      if (hit_h_rdr) h_rdr_ff <= wd;
      if (hit_h_pull) h_pull_ff <= wd;
      if (hit_h_pol) h_pol_ff <= wd;
      if (hit_h_ien) h_ien_ff <= wd;
    end
  end

  // port k: bit 6 has no storage, masked on the way in
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      k_dat_ff <= REG_RESET;
      k_dir_ff <= REG_RESET;
    end else if (wr) begin
      if (hit_k_dat) k_dat_ff <= wd & K_MASK;
      if (hit_k_dir) k_dir_ff <= wd & K_MASK;
    end
  end

  // port m wired-or and routing; unrouted bits never store a one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      m_wom_ff <= REG_RESET;
      route_ff <= REG_RESET;
    end else if (wr) begin
      if (hit_m_wom) m_wom_ff <= wd;
      if (hit_route) route_ff <= wd & ROUTE_MASK;
    end
  end

  // sticky interrupt flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      p_ifl_ff <= REG_RESET;
      h_ifl_ff <= REG_RESET;
    end else begin
      p_ifl_ff <= nxt_p_ifl;
      h_ifl_ff <= nxt_h_ifl;
    end
  end

  // apb answer: zero wait states, error on unmapped address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= RDATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : RDATA_ZERO;
    end
  end

  // port p pads, all registered: one cycle late, glitch-free at the pins;
  // output enables active low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      p_pin_out <= REG_RESET;
      p_pin_oe_n <= 8'hFF;
      p_pull_up <= REG_RESET;
      p_pull_down <= REG_RESET;
      p_drive_reduce <= REG_RESET;
      p_irq_req <= 1'b0;
    end else begin
      p_pin_out <= pad_out(p_periph_own, p_periph_out, p_dat_ff);
      p_pin_oe_n <= ~p_oe;
      p_pull_up <= p_pull_on & ~p_pol_ff;
      p_pull_down <= p_pull_on & p_pol_ff;
      p_drive_reduce <= p_rdr_ff;
      p_irq_req <= |(p_ifl_ff & p_ien_ff);
    end
  end

  // port h pads, same as port p
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      h_pin_out <= REG_RESET;
      h_pin_oe_n <= 8'hFF;
      h_pull_up <= REG_RESET;
      h_pull_down <= REG_RESET;
      h_drive_reduce <= REG_RESET;
      h_irq_req <= 1'b0;
    end else begin
      h_pin_out <= pad_out(h_periph_own, h_periph_out, h_dat_ff);
      h_pin_oe_n <= ~h_oe;
      h_pull_up <= h_pull_on & ~h_pol_ff;
      h_pull_down <= h_pull_on & h_pol_ff;
      h_drive_reduce <= h_rdr_ff;
      h_irq_req <= |(h_ifl_ff & h_ien_ff);
    end
  end

  // port k pads: plain gpio, no peripheral can take them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      k_pin_out <= REG_RESET;
      k_pin_oe_n <= 8'hFF;
    end else begin
      k_pin_out <= k_dat_ff;
      k_pin_oe_n <= ~k_dir_ff;
    end
  end

  // port m settings toward its own pad logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      open_drain_select <= REG_RESET;
      peripheral_routing_bits <= REG_RESET;
    end else begin
      open_drain_select <= m_wom_ff;
      peripheral_routing_bits <= route_ff;
    end
  end

endmodule : gpp_port

// ---- tb/gpp_port_asserts.sv ----
// checker: bus timing and pad relations of the port block
`timescale 1ns/1ps
module gpp_port_asserts
  import gpp_pkg::*;
(
  // clock, reset and bus
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pads and port m settings
  input wire logic [7:0] p_pin_oe_n,
  input wire logic [7:0] p_pull_up,
  input wire logic [7:0] p_pull_down,
  input wire logic [7:0] p_periph_own,
  input wire logic [7:0] peripheral_routing_bits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic wr_dir;
  logic [7:0] wbyte;
  // completed write to the port p direction register
  assign wr_dir = pready && pwrite && pstrb[0] && !pslverr && paddr == {IDX_P_DIR, 2'b00};
  assign wbyte = pwdata[7:0];
  ready_timing_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_zero_a: assert property (pready && pslverr |-> prdata == RDATA_ZERO)
    else $error("error read not zero");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  err_addr_a: assert property (psel && !penable && (paddr[1:0] != 2'b00 ||
    paddr[11:2] < IDX_M_WOM || paddr[11:2] > IDX_K_DIR) |=> pslverr)
    else $error("unmapped not refused");
  route_mask_a: assert property ((peripheral_routing_bits & ~ROUTE_MASK) == 8'h00)
    else $error("routing bit out of mask");
  pull_off_a: assert property (((p_pull_up | p_pull_down) & ~p_pin_oe_n) == 8'h00)
    else $error("pull on driven pin");
  pull_excl_a: assert property ((p_pull_up & p_pull_down) == 8'h00)
    else $error("pull up and down together");
  // two edges: register then pad stage
  dir_drive_a: assert property (wr_dir && p_periph_own == 8'h00 ##1
    p_periph_own == 8'h00 [*2] |-> p_pin_oe_n == ~$past(wbyte, 2)) else $error("dir not on pad");
  reset_pads_a: assert property ($fell(reset) |-> p_pin_oe_n == 8'hFF && !pready)
    else $error("pads not released");
  cover property (wr_dir);
  cover property (pready && pslverr);
  cover property (pready && p_periph_own != 8'h00);
endmodule : gpp_port_asserts

bind gpp_port gpp_port_asserts gpp_port_asserts_i (.clk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .p_pin_oe_n, .p_pull_up,
  .p_pull_down, .p_periph_own, .peripheral_routing_bits);

// ---- tb/gpp_pad_model.sv ----
// pad ring model: level seen on each pin of one port
`timescale 1ns/1ps
module gpp_pad_model (
  // port side
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_down,
  // board driver, weaker than the port
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  logic [7:0] last_ff;
  // a floating pin flips each cycle so no stale level passes
  always_ff @(posedge clk) last_ff <= level;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!oe_n[b]) level[b] = pin_out[b];
      else if (ext_en[b]) level[b] = ext[b];
      else if (pull_up[b]) level[b] = 1'b1;
      else if (pull_down[b]) level[b] = 1'b0;
      else level[b] = ~last_ff[b];
    end
  end
endmodule : gpp_pad_model

// ---- tb/gpp_port_tb.sv ----
// self-checking bench for the port block over apb
`timescale 1ns/1ps
module gpp_port_tb
  import gpp_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, p_irq_req, h_irq_req, err_val;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic [3:0] pstrb;
  logic [7:0] p_pin_in, p_pin_out, p_pin_oe_n, p_pull_up, p_pull_down, p_drive_reduce;
  logic [7:0] h_pin_in, h_pin_out, h_pin_oe_n, h_pull_up, h_pull_down, h_drive_reduce;
  logic [7:0] k_pin_in, k_pin_out, k_pin_oe_n, open_drain_select, peripheral_routing_bits;
  logic [7:0] p_periph_own, p_periph_out, p_periph_oe, h_periph_own, h_periph_out, h_periph_oe;
  logic [7:0] p_ext, h_ext, k_ext;
  int n_mismatch, compares;
  gpp_port gpp_port_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .p_pin_in, .p_pin_out, .p_pin_oe_n, .p_pull_up, .p_pull_down,
    .p_drive_reduce, .h_pin_in, .h_pin_out, .h_pin_oe_n, .h_pull_up, .h_pull_down,
    .h_drive_reduce, .k_pin_in, .k_pin_out, .k_pin_oe_n, .p_periph_own, .p_periph_out,
    .p_periph_oe, .h_periph_own, .h_periph_out, .h_periph_oe, .open_drain_select,
    .peripheral_routing_bits, .p_irq_req, .h_irq_req);
  gpp_pad_model gpp_pad_model_i (.clk, .pin_out(p_pin_out), .oe_n(p_pin_oe_n),
    .pull_up(p_pull_up), .pull_down(p_pull_down), .ext(p_ext), .ext_en(8'hFF), .level(p_pin_in));
  gpp_pad_model gpp_pad_model_h_i (.clk, .pin_out(h_pin_out), .oe_n(h_pin_oe_n),
    .pull_up(h_pull_up), .pull_down(h_pull_down), .ext(h_ext), .ext_en(8'hFF), .level(h_pin_in));
  gpp_pad_model gpp_pad_model_k_i (.clk, .pin_out(k_pin_out), .oe_n(k_pin_oe_n),
    .pull_up(8'h00), .pull_down(8'h00), .ext(k_ext), .ext_en(8'hFF), .level(k_pin_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), rd_val[7:0], e);
  endtask : rd
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, pstrb, p_ext, h_ext} = {4'h8, 44'h0, 4'hF, 16'h0};
    {p_periph_own, p_periph_out, p_periph_oe, h_periph_own, h_periph_out, h_periph_oe} = '0;
    k_ext = 8'h00;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    // all pins low: every register reads zero after reset
    for (int i = 'h256; i <= 'h269; i++) rd(10'(i), 8'h00);
    xfer(1'b1, 10'h26A, 8'hFF);
    chk("slverr", {7'h00, err_val}, 8'h01);
    rd(10'h26A, 8'h00);
    // output mode drives the data bits
    xfer(1'b1, IDX_P_DIR, 8'hFF);
    xfer(1'b1, IDX_P_DATA, 8'h3C);
    repeat (8) @(posedge clk);
    chk("p_pin_out", p_pin_out, 8'h3C);
    chk("p_pin_oe_n", p_pin_oe_n, 8'h00);
    rd(IDX_P_PIN, 8'h3C);
    // input mode: reads show the pin, writes only stored
    p_ext <= 8'h96;
    xfer(1'b1, IDX_P_DIR, 8'h00);
    xfer(1'b1, IDX_P_DATA, 8'h11);
    xfer(1'b1, IDX_P_PULL, 8'hFF);
    xfer(1'b1, IDX_P_POL, 8'h0F);
    repeat (8) @(posedge clk);
    chk("p_pin_oe_n", p_pin_oe_n, 8'hFF);
    rd(IDX_P_DATA, 8'h96);
    chk("p_pull_up", p_pull_up, 8'hF0);
    chk("p_pull_down", p_pull_down, 8'h0F);
    // peripheral takes the low nibble; read source still follows direction
    {p_periph_own, p_periph_out, p_periph_oe} <= {8'h0F, 8'h05, 8'h0F};
    repeat (8) @(posedge clk);
    chk("p_pin_out", p_pin_out & 8'h0F, 8'h05);
    rd(IDX_P_DATA, 8'h95);
    xfer(1'b1, IDX_P_DIR, 8'hFF);
    rd(IDX_P_DATA, 8'h11);
    repeat (2) @(posedge clk);
    chk("p_pull_up", p_pull_up, 8'h00);
    p_periph_own <= 8'h00;
    xfer(1'b1, IDX_P_PIN, 8'h00);
    repeat (8) @(posedge clk);
    rd(IDX_P_PIN, 8'h11);
    // port k bit 6 absent, routing keeps bits 7, 6 and 4
    xfer(1'b1, IDX_K_DIR, 8'hFF);
    xfer(1'b1, IDX_K_DATA, 8'hFF);
    rd(IDX_K_DATA, 8'hBF);
    chk("k_pin_out", k_pin_out, 8'hBF);
    chk("k_pin_oe_n", k_pin_oe_n, 8'h40);
    xfer(1'b1, IDX_ROUTE, 8'hFF);
    xfer(1'b1, IDX_M_WOM, 8'hA5);
    xfer(1'b1, IDX_P_RDR, 8'h81);
    rd(IDX_ROUTE, 8'hD0);
    chk("routing", peripheral_routing_bits, 8'hD0);
    chk("open_drain", open_drain_select, 8'hA5);
    chk("p_drive", p_drive_reduce, 8'h81);
    // byte strobe low: the write is dropped
    pstrb <= 4'h0;
    xfer(1'b1, IDX_P_RDR, 8'h7E);
    pstrb <= 4'hF;
    rd(IDX_P_RDR, 8'h81);
    // port k as input: pins read through, bit 6 still zero
    k_ext <= 8'h5A;
    xfer(1'b1, IDX_K_DIR, 8'h00);
    repeat (8) @(posedge clk);
    rd(IDX_K_DATA, 8'h1A);
    // h: bit 0 flags on rising, bit 1 on falling but masked
    xfer(1'b1, IDX_H_POL, 8'h01);
    xfer(1'b1, IDX_H_IEN, 8'h01);
    h_ext <= 8'h03;
    repeat (8) @(posedge clk);
    rd(IDX_H_IFL, 8'h01);
    chk("h_irq_req", {7'h00, h_irq_req}, 8'h01);
    h_ext <= 8'h01;
    xfer(1'b1, IDX_H_IFL, 8'h01);
    repeat (8) @(posedge clk);
    rd(IDX_H_IFL, 8'h02);
    chk("h_irq_req", {7'h00, h_irq_req}, 8'h00);
    // h pads: pulls split by polarity, data only stored while input
    xfer(1'b1, IDX_H_PULL, 8'h03);
    xfer(1'b1, IDX_H_RDR, 8'h24);
    xfer(1'b1, IDX_H_DATA, 8'h5A);
    repeat (2) @(posedge clk);
    chk("h_pull_up", h_pull_up, 8'h02);
    chk("h_pull_down", h_pull_down, 8'h01);
    chk("h_drive", h_drive_reduce, 8'h24);
    chk("h_pin_out", h_pin_out, 8'h5A);
    chk("h_pin_oe_n", h_pin_oe_n, 8'hFF);
    rd(IDX_H_DATA, 8'h01);
    chk("p_irq_req", {7'h00, p_irq_req}, 8'h00);
    results();
  end
endmodule : gpp_port_tb
